/* hdl/sag_regs.vh */
`ifndef SAG_REGS_VH
`define SAG_REGS_VH
// segment register indices
`define SAG_SEG_EXTRA    3'd0
`define SAG_SEG_CODE     3'd1
`define SAG_SEG_STACK    3'd2
`define SAG_SEG_DATA     3'd3
`define SAG_SEG_EXTRA2   3'd4
`define SAG_SEG_EXTRA3   3'd5
// reference kinds
`define SAG_REF_FETCH    3'd0
`define SAG_REF_PUSH     3'd1
`define SAG_REF_POP      3'd2
`define SAG_REF_STRDST   3'd3
`define SAG_REF_DATA     3'd4
`define SAG_REF_IO       3'd5
// base register code of the data reference
`define SAG_BASE_FRAME   3'd5
`define SAG_BASE_STACK   3'd4
// real-mode selector shift
`define SAG_REAL_SHIFT   4
// page size as offset width
`define SAG_PAGE_BITS    12
// operand sizes
`define SAG_SIZE_BYTE    2'd0
`define SAG_SIZE_WORD    2'd1
`define SAG_SIZE_DWORD   2'd2
// io port source
`define SAG_IO_HI_ZERO   16'h0000
`define SAG_IMM_HI_ZERO  8'h00
`define SAG_ZERO32       32'h0000_0000
`define SAG_ONE32        32'h0000_0001
`endif

/* hdl/sag_seg_select.v */
`timescale 1ns/100ps
`default_nettype none
`include "sag_regs.vh"
// chooses the segment register for one reference
module sag_seg_select (
    input  wire [2:0] ref_kind_i,     // kind of reference
    input  wire [2:0] base_reg_i,     // base register code of the data ref
    input  wire       ovr_valid_i,    // override prefix present
    input  wire [2:0] ovr_seg_i,      // override segment index
    output reg  [2:0] seg_o           // chosen segment index
);
    // default choice, override only where allowed
    always @* begin
        case (ref_kind_i)
            `SAG_REF_FETCH: seg_o = `SAG_SEG_CODE;
            `SAG_REF_PUSH,
            `SAG_REF_POP:   seg_o = `SAG_SEG_STACK;
            `SAG_REF_STRDST: seg_o = `SAG_SEG_EXTRA;
            `SAG_REF_DATA: begin
                if (ovr_valid_i) begin
                    seg_o = ovr_seg_i;
                end else if (base_reg_i == `SAG_BASE_FRAME ||
                             base_reg_i == `SAG_BASE_STACK) begin
                    seg_o = `SAG_SEG_STACK;
                end else begin
                    seg_o = `SAG_SEG_DATA;
                end
            end
            default: seg_o = `SAG_SEG_DATA;
        endcase
    end
endmodule // sag_seg_select
`default_nettype wire

/* hdl/sag_top.v */
`timescale 1ns/100ps
`default_nettype none
`include "sag_regs.vh"
// Functional notes
// - word: two bytes, low byte first
// - dword: four bytes, low byte first
// - operand address is its low byte
// - paging works on 4 Kbyte pages
// - logical address is selector plus offset
// - segmentation yields 32-bit linear address
// - paging off: linear passed out unchanged
// - real mode: selector shl four plus offset
// - protected: descriptor base plus offset
// - segments from one byte to 4 GB
// - fetch always uses code segment
// - stack pushes and pops use stack segment
// - string destination uses extra segment
// - data defaults data, frame/stack base stack
// - overrides replace data default, reach extra segments
// - segment bases may overlap freely
// - 64 Kbyte io space, any port width
// - io addresses bypass translation
// - port from 8-bit immediate or count reg
// - port addresses zero extended
// - memory/io select low for io cycles
module sag_top (
    input  wire        clk_i,          // core clock, 200 MHz
    input  wire        resetn_i,       // async reset, active low
    input  wire        req_i,          // one-cycle address request
    input  wire [2:0]  ref_kind_i,     // kind of reference
    input  wire [2:0]  base_reg_i,     // base register code of data ref
    input  wire        ovr_valid_i,    // segment override present
    input  wire [2:0]  ovr_seg_i,      // override segment index
    input  wire [31:0] base_i,         // base component of offset
    input  wire [31:0] index_i,        // scaled index component
    input  wire [31:0] disp_i,         // displacement component
    input  wire [31:0] ip_i,           // instruction pointer
    input  wire        prot_mode_i,    // 1: protected, 0: real mode
    input  wire        paging_en_i,    // paging enabled
    input  wire [1:0]  op_size_i,      // operand size byte/word/dword
    input  wire [2:0]  byte_idx_i,     // byte of operand being addressed
    input  wire        io_from_count_i,// port from count reg, else immediate
    input  wire [7:0]  io_imm_i,       // 8-bit immediate port
    input  wire [15:0] data_count_reg_16_i, // 16-bit count register
    input  wire [15:0] extra_segment_reg_i,   // segment selectors
    input  wire [15:0] code_segment_reg_i,
    input  wire [15:0] stack_segment_reg_i,
    input  wire [15:0] data_segment_reg_i,
    input  wire [15:0] extra_segment_reg_2_i,
    input  wire [15:0] extra_segment_reg_3_i,
    input  wire [31:0] extra_base_i,   // descriptor bases per segment
    input  wire [31:0] code_base_i,
    input  wire [31:0] stack_base_i,
    input  wire [31:0] data_base_i,
    input  wire [31:0] extra_2_base_i,
    input  wire [31:0] extra_3_base_i,
    output reg         valid_o,        // address valid, one cycle
    output reg  [31:0] addr_o,         // physical address, or linear address when paging is on
    output reg         mem_io_o,       // 1 memory, 0 io
    output reg  [31:0] linear_o,       // linear address for paging unit
    output reg         page_xlate_o,   // linear must be paged
    output reg  [2:0]  seg_o,          // segment used
    output reg  [19:0] page_num_o,     // 4 Kbyte page number
    output reg  [11:0] page_off_o      // offset within page
);
    wire [2:0]  seg_w;         // chosen segment index
    reg  [15:0] sel_w;         // selector of chosen segment
    reg  [31:0] desc_base_w;   // descriptor base of chosen segment
    reg  [31:0] offset_w;      // effective offset
    reg  [31:0] seg_base_w;    // segment base by mode
    reg  [31:0] lin_w;         // linear address of the byte
    reg  [31:0] byte_off_w;    // byte step within operand
    wire [31:0] io_addr_w;     // zero extended port address

    // segment choice per reference kind
    sag_seg_select u_sel (
        .ref_kind_i  (ref_kind_i),
        .base_reg_i  (base_reg_i),
        .ovr_valid_i (ovr_valid_i),
        .ovr_seg_i   (ovr_seg_i),
        .seg_o       (seg_w)
    );

    // selector and descriptor base lookup; bases may overlap
    always @* begin
        case (seg_w)
            `SAG_SEG_EXTRA: begin
                sel_w       = extra_segment_reg_i;
                desc_base_w = extra_base_i;
            end
            `SAG_SEG_CODE: begin
                sel_w       = code_segment_reg_i;
                desc_base_w = code_base_i;
            end
            `SAG_SEG_STACK: begin
                sel_w       = stack_segment_reg_i;
                desc_base_w = stack_base_i;
            end
            `SAG_SEG_EXTRA2: begin
                sel_w       = extra_segment_reg_2_i;
                desc_base_w = extra_2_base_i;
            end
            `SAG_SEG_EXTRA3: begin
                sel_w       = extra_segment_reg_3_i;
                desc_base_w = extra_3_base_i;
            end
            default: begin
                sel_w       = data_segment_reg_i;
                desc_base_w = data_base_i;
            end
        endcase
    end

    // effective offset and operand byte step
    always @* begin
        if (ref_kind_i == `SAG_REF_FETCH) begin
            offset_w = ip_i;
        end else begin
            offset_w = base_i + index_i + disp_i;
        end
        // byte k of an operand lies k above its low byte
        case (op_size_i)
            `SAG_SIZE_WORD:  byte_off_w = {31'd0, byte_idx_i[0]};
            `SAG_SIZE_DWORD: byte_off_w = {30'd0, byte_idx_i[1:0]};
            default:         byte_off_w = `SAG_ZERO32;
        endcase
    end

    // segment base by mode, then linear address
    always @* begin
        if (prot_mode_i) begin
            seg_base_w = desc_base_w;
        end else begin
            seg_base_w = {12'd0, sel_w, 4'd0};
        end
        // full 32-bit wrap covers 1 byte to 4 GB segments
        lin_w = seg_base_w + offset_w + byte_off_w;
    end

    // io port: immediate or count register, zero extended
    assign io_addr_w = io_from_count_i ?
                       {`SAG_IO_HI_ZERO, data_count_reg_16_i} :
                       {`SAG_IO_HI_ZERO, `SAG_IMM_HI_ZERO, io_imm_i};

    // registered outputs
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            valid_o      <= 1'b0;
            addr_o       <= `SAG_ZERO32;
            mem_io_o     <= 1'b1;
            linear_o     <= `SAG_ZERO32;
            page_xlate_o <= 1'b0;
            seg_o        <= `SAG_SEG_DATA;
            page_num_o   <= 20'h0_0000;
            page_off_o   <= 12'h000;
        end else begin
            valid_o <= req_i;
            if (req_i) begin
                if (ref_kind_i == `SAG_REF_IO) begin
                    // io goes out physical, no segment or page step
                    addr_o       <= io_addr_w + byte_off_w;
                    mem_io_o     <= 1'b0;
                    linear_o     <= `SAG_ZERO32;
                    page_xlate_o <= 1'b0;
                    page_num_o   <= 20'h0_0000;
                    page_off_o   <= 12'h000;
                end else begin
                    mem_io_o     <= 1'b1;
                    addr_o       <= lin_w;
                    linear_o     <= lin_w;
                    page_xlate_o <= paging_en_i;
                    seg_o        <= seg_w;
                    // split for 4 Kbyte paging
                    page_num_o   <= lin_w[31:`SAG_PAGE_BITS];
                    page_off_o   <= lin_w[`SAG_PAGE_BITS-1:0];
                end
            end
        end
    end
endmodule // sag_top
`default_nettype wire

/* test/sag_assertions.sv */
`timescale 1ns/100ps
`default_nettype none
// watches segment choice and address form of each answer
module sag_checker (
    input wire        clk_i,
    input wire        resetn_i,
    input wire        req_i,
    input wire [2:0]  ref_kind_i,
    input wire [2:0]  base_reg_i,
    input wire        ovr_valid_i,
    input wire [2:0]  ovr_seg_i,
    input wire        valid_o,
    input wire [31:0] addr_o,
    input wire        mem_io_o,
    input wire [31:0] linear_o,
    input wire [2:0]  seg_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    // kinds: 0 fetch, 1 push, 2 pop, 3 string dest, 4 data, 5 io
    property p_ans; valid_o == $past(req_i); endproperty
    a_ans: assert property (p_ans) else $error("no answer");
    property p_fet; req_i && ref_kind_i == 3'h0 |=> seg_o == 3'h1; endproperty
    a_fet: assert property (p_fet) else $error("fetch seg");
    property p_stk; req_i && (ref_kind_i == 3'h1 || ref_kind_i == 3'h2)
        |=> seg_o == 3'h2; endproperty
    a_stk: assert property (p_stk) else $error("stack seg");
    property p_str; req_i && ref_kind_i == 3'h3 |=> seg_o == 3'h0; endproperty
    a_str: assert property (p_str) else $error("string seg");
    property p_dat; req_i && ref_kind_i == 3'h4 && !ovr_valid_i
        |=> seg_o == (($past(base_reg_i[2:1]) == 2'h2) ? 3'h2 : 3'h3);
    endproperty
    a_dat: assert property (p_dat) else $error("data seg");
    property p_ovr; req_i && ref_kind_i == 3'h4 && ovr_valid_i
        |=> seg_o == $past(ovr_seg_i); endproperty
    a_ovr: assert property (p_ovr) else $error("override seg");
    property p_io; req_i && ref_kind_i == 3'h5 |=> !mem_io_o
        && addr_o[31:16] == 16'h0000 && linear_o == 32'h0000_0000; endproperty
    a_io: assert property (p_io) else $error("io form");
    property p_mem; req_i && ref_kind_i != 3'h5
        |=> mem_io_o && addr_o == linear_o; endproperty
    a_mem: assert property (p_mem) else $error("mem form");
    property p_hold; !req_i |=> $stable(addr_o) && $stable(seg_o); endproperty
    a_hold: assert property (p_hold) else $error("not held");
    c_fet: cover property (req_i && ref_kind_i == 3'h0);
    c_io: cover property (req_i && ref_kind_i == 3'h5);
    c_ovr: cover property (req_i && ovr_valid_i && ref_kind_i == 3'h4);
endmodule // sag_checker
bind sag_top sag_checker u_chk (.clk_i(clk_i), .resetn_i(resetn_i),
    .req_i(req_i), .ref_kind_i(ref_kind_i), .base_reg_i(base_reg_i),
    .ovr_valid_i(ovr_valid_i), .ovr_seg_i(ovr_seg_i), .valid_o(valid_o),
    .addr_o(addr_o), .mem_io_o(mem_io_o), .linear_o(linear_o),
    .seg_o(seg_o));
`default_nettype wire

/* test/sag_bus_model.sv */
`timescale 1ns/100ps
`default_nettype none
// system io decode; no peripheral answers on the reserved ports
module sag_bus_model (
    input  wire        clk_i,
    input  wire        valid_i,  // address strobe
    input  wire [31:0] addr_i,   // physical address
    input  wire        mem_io_i, // 1 memory, 0 io
    output logic       hit_o     // a peripheral claimed the io cycle
);
    // claim io cycles outside 00f8-00ff only
    always @(posedge clk_i) begin
        if (valid_i) begin
            hit_o <= !mem_io_i && addr_i[15:3] != 13'h001F;
        end
    end
endmodule // sag_bus_model
`default_nettype wire

/* test/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
// directed bench for the address generator
module tb_top;
    logic        clk = 1'b0, rst_n = 1'b0, req = 1'b0, ov = 1'b0;
    logic        prot = 1'b0, pg = 1'b0, fromc = 1'b0;
    logic [2:0]  kind = 3'h0, breg = 3'h0, ovs = 3'h0, bi = 3'h0;
    logic [31:0] b = 32'h0, ix = 32'h0, d = 32'h0, ip = 32'h0;
    logic [1:0]  sz = 2'h0;
    logic [7:0]  imm = 8'h00;
    logic [15:0] cnt = 16'h0000;
    logic [15:0] sel [0:5]; // selectors by segment index
    logic [31:0] sb [0:5];  // descriptor bases by segment index
    wire         vld, mio, xl, hit;
    wire [31:0]  addr, lin;
    wire [2:0]   seg;
    wire [19:0]  pn;
    wire [11:0]  po;
    int          err_count = 0, n_compared = 0;
    always #2.5 clk = ~clk;
    sag_top dut (.clk_i(clk), .resetn_i(rst_n), .req_i(req),
        .ref_kind_i(kind), .base_reg_i(breg), .ovr_valid_i(ov),
        .ovr_seg_i(ovs), .base_i(b), .index_i(ix), .disp_i(d), .ip_i(ip),
        .prot_mode_i(prot), .paging_en_i(pg), .op_size_i(sz),
        .byte_idx_i(bi), .io_from_count_i(fromc), .io_imm_i(imm),
        .data_count_reg_16_i(cnt), .extra_segment_reg_i(sel[0]),
        .code_segment_reg_i(sel[1]), .stack_segment_reg_i(sel[2]),
        .data_segment_reg_i(sel[3]), .extra_segment_reg_2_i(sel[4]),
        .extra_segment_reg_3_i(sel[5]), .extra_base_i(sb[0]),
        .code_base_i(sb[1]), .stack_base_i(sb[2]), .data_base_i(sb[3]),
        .extra_2_base_i(sb[4]), .extra_3_base_i(sb[5]), .valid_o(vld),
        .addr_o(addr), .mem_io_o(mio), .linear_o(lin),
        .page_xlate_o(xl), .seg_o(seg), .page_num_o(pn), .page_off_o(po));
    sag_bus_model bus (.clk_i(clk), .valid_i(vld), .addr_i(addr),
        .mem_io_i(mio), .hit_o(hit));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic close_out;
        $display("compared %0d, wrong %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // expected linear address from mode, segment and offset
    function automatic logic [31:0] ex(input int s, input logic [31:0] o);
        ex = prot ? sb[s] + o : {12'h000, sel[s], 4'h0} + o;
    endfunction
    // one request; the valid pulse stands only until the next rising edge
    task automatic fire;
        req = 1'b1;
        @(negedge clk);
        req = 1'b0;
        chk({31'h0, vld}, 32'h1);
    endtask
    // memory answer against expected address and segment
    task automatic mem(input logic [31:0] ea, input logic [2:0] es);
        fire;
        chk(addr, ea);
        chk(lin, ea);
        chk({pn, po}, ea);
        chk({31'h0, mio}, 32'h1);
        chk({29'h0, seg}, {29'h0, es});
    endtask
    task automatic t_fetch;
        ov = 1'b1;
        ip = 32'hFFFF_FFF0;
        mem(ex(1, ip), 3'h1);
        chk({31'h0, xl}, 32'h0);
        $display("fetch test done");
    endtask
    task automatic t_stack;
        prot = 1'b1;
        pg = 1'b1;
        b = 32'h1234_5000;
        ix = 32'h0000_0040;
        d = 32'hFFFF_FFFC;
        for (int k = 1; k < 3; k++) begin
            kind = k[2:0];
            mem(ex(2, b + ix + d), 3'h2);
        end
        chk({31'h0, xl}, 32'h1);
        $display("stack test done");
    endtask
    task automatic t_data;
        kind = 3'h4;
        ov = 1'b0;
        sz = 2'h2;
        bi = 3'h3;
        for (int r = 0; r < 8; r++) begin
            breg = r[2:0];
            mem(ex((r / 2 == 2) ? 2 : 3, b + ix + d) + 32'h3,
                (r / 2 == 2) ? 3'h2 : 3'h3);
        end
        ov = 1'b1;
        for (int s = 0; s < 6; s++) begin
            ovs = s[2:0];
            mem(ex(s, b + ix + d) + 32'h3, s[2:0]);
        end
        kind = 3'h3;
        sz = 2'h1;
        bi = 3'h1;
        mem(ex(0, b + ix + d) + 32'h1, 3'h0);
        $display("data test done");
    endtask
    task automatic t_io;
        kind = 3'h5;
        imm = 8'hF8;
        sz = 2'h0;
        fire;
        @(negedge clk);
        chk(addr, 32'h0000_00F8);
        chk(lin, 32'h0000_0000);
        chk({31'h0, mio}, 32'h0);
        chk({31'h0, hit}, 32'h0);
        fromc = 1'b1;
        cnt = 16'hFFFC;
        sz = 2'h2;
        bi = 3'h3;
        fire;
        @(negedge clk);
        chk(addr, 32'h0000_FFFF);
        chk({31'h0, hit}, 32'h1);
        $display("io test done");
    endtask
    initial begin
        for (int s = 0; s < 6; s++) begin
            sel[s] = {12'hF00, s[3:0]};
            sb[s] = {s[3:0], 28'h000_0000};
        end
        repeat (6) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        t_fetch;
        t_stack;
        t_data;
        t_io;
        close_out;
    end
    // cut a hang short well past the expected run
    initial begin
        #20000;
        err_count++;
        close_out;
    end
endmodule // tb_top
`default_nettype wire
